// ---- rtl/sofc_device.sv ----
// serial output format device: config registers, bit mapper, serializer
// Operation
// - frame source bit picks core or decimation frame
// - host sets source only complex 2/1-wire
// - host sets divide only 2-wire bypass/real
// - toggle stretches half-wire frame over both channels
// - half swing bit halves lane drive current
// - mapper enable applies resolution in bypass
// - wide enable gives 20-bit words
// - resolution code picks 18, 16, 14 bits
// - bypass needs mapper enable, decimation does not
// - data skew code shifts lane timing
// - bit clock skew code, same encoding
// - bypass frame pattern follows resolution automatically
// - feature path enable inserts decimation path
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "sofc_map.svh"
module sofc_device (
  sofc_if.dev                   link,
  input  wire logic             nrst,
  input  wire logic [19:0]      sampleA,
  input  wire logic [19:0]      sampleB,
  input  wire sofc_pkg::sofc_lane_e laneSel,
  input  wire sofc_pkg::sofc_dec_e  decMode,
  input  wire logic             pathEnable,
  input  wire logic             decFrame,
  output logic                  driveHalf,
  output logic [1:0]            dataSkew,
  output logic [1:0]            bitClockSkew,
  output logic [4:0]            wordWidth,
  output logic                  wordStart
);
  import sofc_pkg::*;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [4:0] widthOf(input logic [2:0] code);
    logic [4:0] w;
    w = `SOFC_WIDTH_18;
    if (code == `SOFC_RES_16) begin
      w = `SOFC_WIDTH_16;
    end else if (code == `SOFC_RES_14) begin
      w = `SOFC_WIDTH_14;
    end
    return w;
  endfunction

  function automatic logic [5:0] periodOf(input sofc_lane_e lane,
                                          input logic [4:0] w);
    logic [5:0] p;
    p = {1'b0, w};
    if (lane == LANE_TWO) begin
      p = {2'b00, w[4:1]};
    end else if (lane == LANE_HALF) begin
      p = {w, 1'b0};
    end
    return p;
  endfunction

  // bit k counted from the msb of a left aligned 20-bit sample
  function automatic logic bitAt(input logic [19:0] word,
                                 input logic [5:0]  k);
    logic b;
    b = 1'b0;
    if (k < 6'h14) begin
      b = word[5'h13 - k[4:0]];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  sofc_byte_t frameCfg;
  sofc_byte_t driveCfg;
  sofc_byte_t mapCfg;
  sofc_byte_t skewCfg;

  wire hitFrame = link.cfgAddr == `SOFC_FRAME_CFG_ADDR;
  wire hitDrive = link.cfgAddr == `SOFC_DRIVE_ADDR;
  wire hitMap   = link.cfgAddr == `SOFC_MAPPER_ADDR;
  wire hitSkew  = link.cfgAddr == `SOFC_SKEW_ADDR;

  // reserved positions are dropped on write and read back as zero
  wire sofc_byte_t wrFrame = link.cfgWdata & `SOFC_FC_MASK;
  wire sofc_byte_t wrDrive = link.cfgWdata & `SOFC_DRV_MASK;
  wire sofc_byte_t wrMap   = link.cfgWdata & `SOFC_MAP_MASK;
  wire sofc_byte_t wrSkew  = link.cfgWdata & `SOFC_SKEW_MASK;

  wire sofc_byte_t rdSel =
      hitFrame ? frameCfg :
      hitDrive ? driveCfg :
      hitMap   ? mapCfg   :
      hitSkew  ? skewCfg  : `SOFC_REG_RESET;

  always_ff @(posedge link.lclk or negedge nrst) begin
    if (!nrst) begin
      frameCfg <= `SOFC_REG_RESET;
      driveCfg <= `SOFC_REG_RESET;
      mapCfg   <= `SOFC_REG_RESET;
      skewCfg  <= `SOFC_REG_RESET;
    end else if (link.cfgWr) begin
      if (hitFrame) frameCfg <= wrFrame;
      if (hitDrive) driveCfg <= wrDrive;
      if (hitMap)   mapCfg   <= wrMap;
      if (hitSkew)  skewCfg  <= wrSkew;
    end
  end

  always_ff @(posedge link.lclk or negedge nrst) begin
    if (!nrst) begin
      link.cfgRdata <= `SOFC_REG_RESET;
    end else if (link.cfgRd) begin
      link.cfgRdata <= rdSel;
    end
  end

  // ----------------------------------------------------------------------
  // analog trims
  // ----------------------------------------------------------------------
  // these codes steer the lane drivers and delay cells outside this logic
  assign driveHalf    = driveCfg[`SOFC_DRV_HALF_BIT];
  assign dataSkew     =
      skewCfg[`SOFC_SKEW_DATA_HI:`SOFC_SKEW_DATA_LO];
  assign bitClockSkew =
      skewCfg[`SOFC_SKEW_CLK_HI:`SOFC_SKEW_CLK_LO];

  // ----------------------------------------------------------------------
  // bit mapper
  // ----------------------------------------------------------------------
  // without the feature path the decimator is out, so it acts as bypass
  wire effBypass = !pathEnable || decMode == DEC_BYPASS;
  wire mapOn     = effBypass ? mapCfg[`SOFC_MAP_EN_BIT]
                             : 1'b1;
  wire [2:0] resCode = mapCfg[`SOFC_MAP_RES_HI:`SOFC_MAP_RES_LO];
  wire [4:0] mappedW = mapOn ? widthOf(resCode)
                             : `SOFC_WIDTH_18;
  wire [4:0] selW    = mapCfg[`SOFC_MAP_WIDE_BIT] ? `SOFC_WIDTH_20
                                                  : mappedW;

  // ----------------------------------------------------------------------
  // serializer state
  // ----------------------------------------------------------------------
  // width and lane mode only change at a word boundary so that a write
  // in mid word never produces a truncated or mixed word on the lanes
  logic [4:0]  curW;
  sofc_lane_e  curLane;
  logic [5:0]  idx;
  logic [19:0] wa;
  logic [19:0] wb;
  logic        wordPhase;

  wire [5:0] period  = periodOf(curLane, curW);
  wire       lastBit = idx == period - 6'h01;
  wire [5:0] halfW   = {2'b00, curW[4:1]};
  wire [5:0] fullW   = {1'b0, curW};
  wire       inA     = idx < fullW;
  wire [5:0] chIdx   = inA ? idx : idx - fullW;

  always_ff @(posedge link.lclk or negedge nrst) begin
    if (!nrst) begin
      curW      <= `SOFC_WIDTH_18;
      curLane   <= LANE_ONE;
      idx       <= 6'h00;
      wa        <= 20'h00000;
      wb        <= 20'h00000;
      wordPhase <= 1'b0;
    end else if (lastBit) begin
      curW      <= selW;
      curLane   <= laneSel;
      idx       <= 6'h00;
      wa        <= sampleA;
      wb        <= sampleB;
      wordPhase <= !wordPhase;
    end else begin
      idx <= idx + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // lane data
  // ----------------------------------------------------------------------
  logic next_laneA;
  logic next_laneB;

  always_comb begin
    next_laneA = 1'b0;
    next_laneB = 1'b0;
    unique case (curLane)
      LANE_TWO: begin
        next_laneA = bitAt(wa, idx);
        next_laneB = bitAt(wa, idx + halfW);
      end
      LANE_ONE: begin
        next_laneA = bitAt(wa, idx);
        next_laneB = bitAt(wb, idx);
      end
      LANE_HALF: begin
        next_laneA = inA ? bitAt(wa, chIdx) : bitAt(wb, chIdx);
      end
      default: begin
        next_laneA = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // frame clock
  // ----------------------------------------------------------------------
  // the pattern is derived from the live word width, so a resolution
  // change needs no separate frame pattern write
  wire frameBase = idx < {1'b0, period[5:1]};
  wire frameHalf = frameCfg[`SOFC_FC_TOG_BIT] ? inA
                 : chIdx < {1'b0, halfW[5:1]};
  wire frameCore = frameCfg[`SOFC_FC_DIV_BIT] ? wordPhase
                 : (curLane == LANE_HALF ? frameHalf
                                         : frameBase);
  wire next_frame = frameCfg[`SOFC_FC_SRC_BIT] ? decFrame
                                               : frameCore;

  always_ff @(posedge link.lclk or negedge nrst) begin
    if (!nrst) begin
      link.laneA      <= 1'b0;
      link.laneB      <= 1'b0;
      link.frameClock <= 1'b0;
      wordWidth       <= `SOFC_WIDTH_18;
      wordStart       <= 1'b0;
    end else begin
      link.laneA      <= next_laneA;
      link.laneB      <= next_laneB;
      link.frameClock <= next_frame;
      wordWidth       <= curW;
      wordStart       <= idx == 6'h00;
    end
  end
endmodule

// ---- rtl/sofc_map.svh ----
// register offsets, field positions, reset values and host map of the block
`ifndef SOFC_MAP_SVH
`define SOFC_MAP_SVH

// ----------------------------------------------------------------------
// device register offsets
// ----------------------------------------------------------------------
`define SOFC_FRAME_CFG_ADDR   8'h19
`define SOFC_DRIVE_ADDR       8'h1A
`define SOFC_MAPPER_ADDR      8'h1B
`define SOFC_SKEW_ADDR        8'h1E

// ----------------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------------
`define SOFC_FC_SRC_BIT       7
`define SOFC_FC_DIV_BIT       4
`define SOFC_FC_TOG_BIT       0
`define SOFC_FC_MASK          8'h91
`define SOFC_DRV_HALF_BIT     6
`define SOFC_DRV_MASK         8'h40
`define SOFC_MAP_EN_BIT       7
`define SOFC_MAP_WIDE_BIT     6
`define SOFC_MAP_RES_HI       5
`define SOFC_MAP_RES_LO       3
`define SOFC_MAP_MASK         8'hF8
`define SOFC_SKEW_DATA_HI     3
`define SOFC_SKEW_DATA_LO     2
`define SOFC_SKEW_CLK_HI      1
`define SOFC_SKEW_CLK_LO      0
`define SOFC_SKEW_MASK        8'h0F
`define SOFC_REG_RESET        8'h00

// ----------------------------------------------------------------------
// resolution codes and word widths
// ----------------------------------------------------------------------
`define SOFC_RES_18           3'h0
`define SOFC_RES_16           3'h1
`define SOFC_RES_14           3'h2
`define SOFC_WIDTH_20         5'h14
`define SOFC_WIDTH_18         5'h12
`define SOFC_WIDTH_16         5'h10
`define SOFC_WIDTH_14         5'h0E

// ----------------------------------------------------------------------
// host software port
// ----------------------------------------------------------------------
`define SOFC_HOST_MODE        4'h0
`define SOFC_HOST_WRITE       4'h1
`define SOFC_HOST_READ        4'h2
`define SOFC_HOST_STATUS      4'h3
`define SOFC_HOST_BUSY_BIT    15

`endif

// ---- rtl/sofc_pkg.sv ----
// types shared by both ends of the serial output format link
package sofc_pkg;

  typedef enum logic [1:0] {
    LANE_TWO,
    LANE_ONE,
    LANE_HALF
  } sofc_lane_e;

  typedef enum logic [1:0] {
    DEC_BYPASS,
    DEC_REAL,
    DEC_COMPLEX
  } sofc_dec_e;

  typedef logic [7:0] sofc_byte_t;

endpackage

// ---- rtl/sofc_if.sv ----
// link between the configuring host and the serial output device
`timescale 1ns/1ns
interface sofc_if (
  input logic lclk
);
  logic [7:0] cfgAddr;
  logic [7:0] cfgWdata;
  logic       cfgWr;
  logic       cfgRd;
  logic [7:0] cfgRdata;
  logic       laneA;
  logic       laneB;
  logic       frameClock;

  modport dev (
    input  lclk,
    input  cfgAddr,
    input  cfgWdata,
    input  cfgWr,
    input  cfgRd,
    output cfgRdata,
    output laneA,
    output laneB,
    output frameClock
  );

  modport host (
    input  lclk,
    output cfgAddr,
    output cfgWdata,
    output cfgWr,
    output cfgRd,
    input  cfgRdata,
    input  laneA,
    input  laneB,
    input  frameClock
  );
endinterface

// ---- rtl/sofc_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sofc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  // stage1 is read only by dout to keep metastability contained
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ---- rtl/sofc_host.sv ----
// configuring host: software orders, link access to the device registers
`timescale 1ns/1ns
`include "sofc_map.svh"
module sofc_host (
  sofc_if.host              link,
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [15:0]       rdata
);
  import sofc_pkg::*;

  typedef enum logic [1:0] {
    L_IDLE,
    L_ISSUE,
    L_CAPT
  } sofc_lstate_e;

  // ----------------------------------------------------------------------
  // shaping of outgoing register values
  // ----------------------------------------------------------------------
  function automatic sofc_byte_t shape(input sofc_byte_t a,
                                       input sofc_byte_t d,
                                       input sofc_lane_e lane,
                                       input sofc_dec_e  dec);
    sofc_byte_t v;
    v = `SOFC_REG_RESET;
    if (a == `SOFC_FRAME_CFG_ADDR) begin
      // real decimation is treated like bypass here
      v[`SOFC_FC_SRC_BIT] = dec == DEC_COMPLEX
                          && lane != LANE_HALF;
      v[`SOFC_FC_DIV_BIT] = dec != DEC_COMPLEX
                          && lane == LANE_TWO;
      v[`SOFC_FC_TOG_BIT] = dec == DEC_COMPLEX
                          && lane == LANE_HALF;
    end else if (a == `SOFC_DRIVE_ADDR) begin
      v = d & `SOFC_DRV_MASK;
    end else if (a == `SOFC_MAPPER_ADDR) begin
      v = d & `SOFC_MAP_MASK;
      v[`SOFC_MAP_EN_BIT] = dec == DEC_BYPASS;
    end else if (a == `SOFC_SKEW_ADDR) begin
      v = d & `SOFC_SKEW_MASK;
    end else begin
      v = d;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // software side
  // ----------------------------------------------------------------------
  logic [3:0] mode;
  logic       busy;
  logic       reqT;
  logic       ackSeen;
  logic       ackS;
  sofc_byte_t cmdAddr;
  sofc_byte_t cmdData;
  logic       cmdRead;
  sofc_byte_t lastRd;
  logic       ackT;
  sofc_byte_t rdL;

  wire sofc_lane_e modeLane = sofc_lane_e'(mode[1:0]);
  wire sofc_dec_e  modeDec  = sofc_dec_e'(mode[3:2]);
  wire startWr = wr && !busy && addr == `SOFC_HOST_WRITE;
  wire startRd = wr && !busy && addr == `SOFC_HOST_READ;
  wire done    = busy && ackS != ackSeen;
  wire [15:0] rdSel =
      addr == `SOFC_HOST_MODE   ? {12'h000, mode} :
      addr == `SOFC_HOST_STATUS ? {busy, 7'h00, lastRd} : 16'h0000;

  sofc_sync u_ackSync (
    .clk  (clk),
    .nrst (nrst),
    .din  (ackT),
    .dout (ackS)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode    <= 4'h0;
      busy    <= 1'b0;
      reqT    <= 1'b0;
      ackSeen <= 1'b0;
      cmdAddr <= `SOFC_REG_RESET;
      cmdData <= `SOFC_REG_RESET;
      cmdRead <= 1'b0;
      lastRd  <= `SOFC_REG_RESET;
      rdata   <= 16'h0000;
    end else begin
      rdata <= rd ? rdSel : 16'h0000;
      if (wr && addr == `SOFC_HOST_MODE) mode <= wdata[3:0];
      if (startWr || startRd) begin
        // command fields stay frozen until the link side acknowledges
        cmdAddr <= wdata[15:8];
        cmdData <= shape(wdata[15:8], wdata[7:0], modeLane, modeDec);
        cmdRead <= startRd;
        reqT    <= !reqT;
        busy    <= 1'b1;
      end else if (done) begin
        ackSeen <= ackS;
        busy    <= 1'b0;
        if (cmdRead) lastRd <= rdL;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------------
  logic         reqS;
  logic         reqSeen;
  sofc_lstate_e lstate;

  sofc_sync u_reqSync (
    .clk  (link.lclk),
    .nrst (nrst),
    .din  (reqT),
    .dout (reqS)
  );

  always_ff @(posedge link.lclk or negedge nrst) begin
    if (!nrst) begin
      lstate        <= L_IDLE;
      reqSeen       <= 1'b0;
      ackT          <= 1'b0;
      rdL           <= `SOFC_REG_RESET;
      link.cfgAddr  <= `SOFC_REG_RESET;
      link.cfgWdata <= `SOFC_REG_RESET;
      link.cfgWr    <= 1'b0;
      link.cfgRd    <= 1'b0;
    end else begin
      unique case (lstate)
        L_IDLE: begin
          if (reqS != reqSeen) begin
            reqSeen       <= reqS;
            link.cfgAddr  <= cmdAddr;
            link.cfgWdata <= cmdData;
            link.cfgWr    <= !cmdRead;
            link.cfgRd    <= cmdRead;
            lstate        <= L_ISSUE;
          end
        end
        L_ISSUE: begin
          link.cfgWr <= 1'b0;
          link.cfgRd <= 1'b0;
          lstate     <= L_CAPT;
        end
        L_CAPT: begin
          rdL    <= link.cfgRdata;
          ackT   <= !ackT;
          lstate <= L_IDLE;
        end
        default: begin
          lstate <= L_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- sim/sofc_sva.sv ----
// link-side checker for the serial output format configuration link
`timescale 1ns/1ns
`include "sofc_map.svh"
module sofc_sva (
  input wire logic       lclk,
  input wire logic       nrst,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWdata,
  input wire logic       cfgWr,
  input wire logic       cfgRd,
  input wire logic [7:0] cfgRdata,
  input wire logic       frameClock
);
  default clocking cb @(posedge lclk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------
  logic [7:0] shFc;
  logic [7:0] shDrv;
  logic [7:0] shMap;
  logic [7:0] shSkew;
  logic [7:0] stillCnt;
  wire  [7:0] resvMask;
  wire  [7:0] shSel;
  wire        mapped;

  // unmapped places read as all reserved
  assign resvMask = (cfgAddr == `SOFC_FRAME_CFG_ADDR) ? ~`SOFC_FC_MASK :
                    (cfgAddr == `SOFC_DRIVE_ADDR)     ? ~`SOFC_DRV_MASK :
                    (cfgAddr == `SOFC_MAPPER_ADDR)    ? ~`SOFC_MAP_MASK :
                    (cfgAddr == `SOFC_SKEW_ADDR)      ? ~`SOFC_SKEW_MASK :
                                                        8'hFF;
  assign mapped   = (resvMask != 8'hFF);
  assign shSel    = (cfgAddr == `SOFC_FRAME_CFG_ADDR) ? shFc :
                    (cfgAddr == `SOFC_DRIVE_ADDR)     ? shDrv :
                    (cfgAddr == `SOFC_MAPPER_ADDR)    ? shMap : shSkew;

  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      shFc   <= 8'h00;
      shDrv  <= 8'h00;
      shMap  <= 8'h00;
      shSkew <= 8'h00;
    end else if (cfgWr) begin
      if (cfgAddr == `SOFC_FRAME_CFG_ADDR) shFc <= cfgWdata & ~resvMask;
      if (cfgAddr == `SOFC_DRIVE_ADDR) shDrv <= cfgWdata & ~resvMask;
      if (cfgAddr == `SOFC_MAPPER_ADDR) shMap <= cfgWdata & ~resvMask;
      if (cfgAddr == `SOFC_SKEW_ADDR) shSkew <= cfgWdata & ~resvMask;
    end
  end

  // a frame clock stuck for longer than any word pattern means it died
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      stillCnt <= 8'h00;
    end else begin
      stillCnt <= $changed(frameClock) ? 8'h00 : stillCnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_strobe_excl: assert property (!(cfgWr && cfgRd))
    else $error("write and read strobe together");
  chk_access_gap: assert property ((cfgWr || cfgRd) |=>
    !(cfgWr || cfgRd) [*2])
    else $error("link accesses closer than three cycles");
  chk_frame_legal: assert property (
    cfgWr && cfgAddr == `SOFC_FRAME_CFG_ADDR |->
    cfgWdata inside {8'h00, 8'h10, 8'h80, 8'h01})
    else $error("illegal frame clock setting written");
  chk_wr_reserved: assert property (cfgWr && mapped |->
    (cfgWdata & resvMask) == 8'h00)
    else $error("reserved bit written as one");
  chk_read_back: assert property (cfgRd && mapped |=>
    cfgRdata == $past(shSel))
    else $error("register read differs from last write");
  chk_read_zero: assert property (cfgRd |=>
    (cfgRdata & $past(resvMask)) == 8'h00)
    else $error("reserved or unmapped bits read as one");
  chk_rd_hold: assert property (!cfgRd |=> $stable(cfgRdata))
    else $error("read data moved without a read");
  chk_frame_alive: assert property (stillCnt < 8'h51)
    else $error("frame clock stopped");
endmodule

// ---- sim/serial_output_format_config_tb.sv ----
// self-checking bench: host and device joined across the link
`timescale 1ns/1ns
module serial_output_format_config_tb;
  import sofc_pkg::*;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0]  dfCnt = 3'h0;
  logic        decFrame = 1'b0;
  logic        pathEnable = 1'b1;
  sofc_lane_e  laneSel = LANE_ONE;
  sofc_dec_e   decMode = DEC_BYPASS;
  logic        driveHalf;
  logic [1:0]  dataSkew;
  logic [1:0]  bitClockSkew;
  logic [4:0]  wordWidth;
  logic        wordStart;
  logic [15:0] rv;
  int          fails = 0;
  int          testsRun = 0;
  int          cycles = 0;
  logic [7:0]  offs [5] = '{8'h19, 8'h1A, 8'h1B, 8'h1E, 8'h20};
  logic [1:0]  fLane [7] = '{0, 1, 2, 0, 0, 1, 2};
  logic [1:0]  fDec [7] = '{0, 0, 0, 1, 2, 2, 2};
  logic [7:0]  fExp [7] = '{8'h10, 8'h00, 8'h00, 8'h10, 8'h80, 8'h80, 8'h01};
  logic [1:0]  mDec [8] = '{0, 0, 0, 0, 0, 1, 2, 0};
  logic [7:0]  mWr [8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h40, 8'h08, 8'h10,
                           8'h0F};
  logic [7:0]  mRd [8] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'hC0, 8'h08, 8'h10,
                           8'h88};
  logic [4:0]  mW [8] = '{5'h12, 5'h10, 5'h0E, 5'h12, 5'h14, 5'h10, 5'h0E,
                          5'h10};

  always #2 clk = ~clk;
  // odd start offset keeps the link clock out of phase with clk
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  always @(posedge lclk) begin
    dfCnt <= dfCnt + 3'h1;
    decFrame <= dfCnt[2];
  end

  sofc_if link (.lclk(lclk));
  sofc_host i_sofc_host (.link(link), .clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  sofc_device i_sofc_device (.link(link), .nrst(nrst),
    .sampleA(20'hA5C3F), .sampleB(20'h3C96A), .laneSel(laneSel),
    .decMode(decMode), .pathEnable(pathEnable), .decFrame(decFrame),
    .driveHalf(driveHalf), .dataSkew(dataSkew),
    .bitClockSkew(bitClockSkew), .wordWidth(wordWidth),
    .wordStart(wordStart));
  sofc_sva i_sofc_sva (.lclk(lclk), .nrst(nrst), .cfgAddr(link.cfgAddr),
    .cfgWdata(link.cfgWdata), .cfgWr(link.cfgWr), .cfgRd(link.cfgRd),
    .cfgRdata(link.cfgRdata), .frameClock(link.frameClock));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic hr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic devw(input logic [7:0] a, input logic [7:0] d);
    int i;
    hw(4'h1, {a, d});
    for (i = 0; i < 100; i++) begin
      hr(4'h3, rv);
      if (rv[15] === 1'b0) break;
    end
    // a host that never comes back is a failure, not a silent skip
    if (rv[15] !== 1'b0) begin
      fails++;
      $display("unexpected at %0t: host order never finished", $time);
    end
  endtask

  // lanes sampled mid cycle, first bit is the one beside wordStart
  task automatic laneChk(input logic [15:0] expA, input logic [15:0] expB);
    logic [15:0] sa;
    logic [15:0] sb;
    int i;
    sa = 16'h0000;
    sb = 16'h0000;
    @(negedge lclk);
    for (i = 0; i < 100 && wordStart !== 1'b1; i++) @(negedge lclk);
    for (i = 0; i < 16; i++) begin
      sa = {sa[14:0], link.laneA};
      sb = {sb[14:0], link.laneB};
      @(negedge lclk);
    end
    check(sa, expA);
    check(sb, expB);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    devw(a, 8'h00);
    check({8'h00, rv[7:0]}, {8'h00, exp});
  endtask

  task automatic setMode(input logic [1:0] lane, input logic [1:0] dec);
    @(posedge lclk);
    laneSel <= sofc_lane_e'(lane);
    decMode <= sofc_dec_e'(dec);
    hw(4'h0, {12'h000, dec, lane});
  endtask

  task automatic waitWidth(input logic [4:0] exp);
    int i;
    for (i = 0; i < 200 && wordWidth !== exp; i++) @(posedge lclk);
    check({11'h000, wordWidth}, {11'h000, exp});
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails++;
      test_done();
    end
  end

  // reads reuse devw's poll path, so a read order is a write to slot 2
  initial begin
    repeat (16) @(posedge clk);
    repeat (2) @(posedge lclk);
    check({11'h000, wordWidth}, 16'h0012);
    @(posedge clk);
    nrst <= 1'b1;
    foreach (offs[i]) begin
      hw(4'h2, {offs[i], 8'h00});
      rdchk(8'h00, 8'h00);
    end
    devw(8'h1A, 8'hFF);
    check({15'h0000, driveHalf}, 16'h0001);
    hw(4'h2, {8'h1A, 8'h00});
    rdchk(8'h00, 8'h40);
    devw(8'h1A, 8'h00);
    check({15'h0000, driveHalf}, 16'h0000);
    for (int j = 0; j < 4; j++) begin
      devw(8'h1E, {4'h0, j[1:0], ~j[1:0]});
      check({14'h0000, dataSkew}, {14'h0000, j[1:0]});
      check({14'h0000, bitClockSkew}, {14'h0000, ~j[1:0]});
    end
    for (int j = 0; j < 7; j++) begin
      setMode(fLane[j], fDec[j]);
      hr(4'h0, rv);
      check(rv, {12'h000, fDec[j], fLane[j]});
      devw(8'h19, 8'hFF);
      hw(4'h2, {8'h19, 8'h00});
      rdchk(8'h00, fExp[j]);
      repeat (100) @(posedge lclk);
    end
    for (int j = 0; j < 8; j++) begin
      setMode(2'h1, mDec[j]);
      devw(8'h1B, mWr[j]);
      hw(4'h2, {8'h1B, 8'h00});
      rdchk(8'h00, mRd[j]);
      waitWidth(mW[j]);
    end
    // one-wire, 16 bits: each lane carries the top 16 bits of its sample
    laneChk(16'hA5C3, 16'h3C96);
    // without the feature path real decimation falls back to bypass
    @(posedge lclk);
    pathEnable <= 1'b0;
    setMode(2'h1, 2'h1);
    devw(8'h1B, 8'h08);
    waitWidth(5'h12);
    test_done();
  end
endmodule
